//--- design/ubg_majority_sampler.sv
module ubg_majority_sampler
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Pin and sampling strobe
  input wire logic receive_pin_i,
  input wire logic sample_en_i,
  // Resolved level
  output logic rx_level_o
);

  typedef struct packed
  {
    logic sync1;
    logic sync2;
    logic [2:0] samples;
    logic level;
  } ubg_smp_state_t;

  ubg_smp_state_t s_q;
  ubg_smp_state_t s_d;

  // ==========================================================
  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.sync1 = receive_pin_i;
    s_d.sync2 = s_q.sync1;
    if (sample_en_i)
    begin
      s_d.samples = {s_q.samples[1:0], s_q.sync2};
    end
    // Two of three wins; one glitchy sample cannot flip the level
    s_d.level = (s_q.samples[0] & s_q.samples[1]) | (s_q.samples[1] & s_q.samples[2]) |
      (s_q.samples[0] & s_q.samples[2]);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      s_q.sync1 <= 1'b1;
      s_q.sync2 <= 1'b1;
      s_q.samples <= ubg_pkg::SAMPLES_RESET;
      s_q.level <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rx_level_o = s_q.level;

endmodule : ubg_majority_sampler

//--- design/ubg_pkg.sv
// Notes on behaviour
// - Receive pin level is the majority of three samples.
// - Async, narrow divider, low speed: rate is clock over 64 times (n+1).
// - Async, wide divider, low speed: rate is clock over 16 times (n+1).
// - Divisor n is the high byte above the low byte, unsigned.
// - Narrow selection uses only the low byte; wide uses all 16 bits.
// - Writing either divisor byte clears the divider timer at once.
// - High speed matters only in async; in sync, generation only as clock master.
package ubg_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] OFS_TX_CTRL = 8'h00;
  localparam logic [7:0] OFS_RX_CTRL = 8'h04;
  localparam logic [7:0] OFS_BAUD_CTRL = 8'h08;
  localparam logic [7:0] OFS_DIV_LOW = 8'h0C;
  localparam logic [7:0] OFS_DIV_HIGH = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ==========================================================
  // Field positions
  localparam int TX_CLK_MASTER_BIT = 7;
  localparam int TX_SYNC_MODE_BIT = 4;
  localparam int TX_HIGH_SPEED_BIT = 2;
  localparam int RX_PORT_ENABLE_BIT = 7;
  localparam int BAUD_WIDE_DIV_BIT = 3;
  localparam int STAT_RX_LEVEL_BIT = 0;
  localparam int STAT_RUNNING_BIT = 1;

  // Writable bits; reserved bits read as zero
  localparam logic [7:0] TX_WR_MASK = 8'hFD;
  localparam logic [7:0] RX_WR_MASK = 8'hF9;
  localparam logic [7:0] BAUD_WR_MASK = 8'h1B;

  // ==========================================================
  // Reset values
  localparam logic [7:0] TX_RESET = 8'h00;
  localparam logic [7:0] RX_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [5:0] POST_RESET = 6'h00;
  localparam logic [2:0] SAMPLES_RESET = 3'h7;

  // ==========================================================
  // Postscale last counts: factor minus one
  localparam logic [5:0] POST_LAST_X64 = 6'h3F;
  localparam logic [5:0] POST_LAST_X16 = 6'h0F;
  localparam logic [5:0] POST_LAST_X4 = 6'h03;

  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [5:0] POST_STEP = 6'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

endpackage : ubg_pkg

//--- design/ubg_rate_divider.sv
module ubg_rate_divider
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [15:0] divisor_i,
  input wire logic [5:0] post_last_i,
  // Ticks
  output logic timer_tick_o,
  output logic baud_tick_o
);

  typedef struct packed
  {
    logic [15:0] count;
    logic [5:0] post;
    logic timer_tick;
    logic baud_tick;
  } ubg_div_state_t;

  ubg_div_state_t s_q;
  ubg_div_state_t s_d;

  logic count_wrap;
  logic post_wrap;

  assign count_wrap = (s_q.count >= divisor_i);
  assign post_wrap = (s_q.post >= post_last_i);

  // ==========================================================
  // Free-running timer with postscaler
  always_comb
  begin
    s_d = s_q;
    s_d.timer_tick = 1'b0;
    s_d.baud_tick = 1'b0;
    if (!run_i || clear_i)
    begin
      // New divisor starts from zero, no wait for old overflow
      s_d.count = ubg_pkg::COUNT_RESET;
      s_d.post = ubg_pkg::POST_RESET;
    end
    else if (count_wrap)
    begin
      s_d.count = ubg_pkg::COUNT_RESET;
      s_d.timer_tick = 1'b1;
      if (post_wrap)
      begin
        s_d.post = ubg_pkg::POST_RESET;
        s_d.baud_tick = 1'b1;
      end
      else
      begin
        s_d.post = s_q.post + ubg_pkg::POST_STEP;
      end
    end
    else
    begin
      s_d.count = s_q.count + ubg_pkg::COUNT_STEP;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      s_q.count <= ubg_pkg::COUNT_RESET;
      s_q.post <= ubg_pkg::POST_RESET;
      s_q.timer_tick <= 1'b0;
      s_q.baud_tick <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign timer_tick_o = s_q.timer_tick;
  assign baud_tick_o = s_q.baud_tick;

endmodule : ubg_rate_divider

//--- design/ubg_top.sv
// Local design decisions: the placing of the registers and the APB register port.
module ubg_top
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Serial line
  input wire logic receive_pin_i,
  // To transmitter and receiver units
  output logic baud_tick_o,
  output logic rx_level_o
);

  typedef struct packed
  {
    logic [7:0] tx_status_control;
    logic [7:0] rx_status_control;
    logic [7:0] baud_control;
    logic [7:0] divisor_low_byte;
    logic [7:0] divisor_high_byte;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ubg_top_state_t;

  ubg_top_state_t s_q;
  ubg_top_state_t s_d;

  // ==========================================================
  // Decode
  logic access;
  logic do_write;
  logic low_lane;
  logic aligned;
  logic hit_tx;
  logic hit_rx;
  logic hit_baud;
  logic hit_lo;
  logic hit_hi;
  logic hit_stat;
  logic mapped;
  logic div_write;

  assign access = psel_i & penable_i & s_q.pready;
  assign do_write = access & pwrite_i;
  assign low_lane = pstrb_i[0];
  assign aligned = (paddr_i[1:0] == ubg_pkg::WORD_ALIGN);
  assign hit_tx = aligned & (paddr_i == ubg_pkg::OFS_TX_CTRL);
  assign hit_rx = aligned & (paddr_i == ubg_pkg::OFS_RX_CTRL);
  assign hit_baud = aligned & (paddr_i == ubg_pkg::OFS_BAUD_CTRL);
  assign hit_lo = aligned & (paddr_i == ubg_pkg::OFS_DIV_LOW);
  assign hit_hi = aligned & (paddr_i == ubg_pkg::OFS_DIV_HIGH);
  assign hit_stat = aligned & (paddr_i == ubg_pkg::OFS_STATUS);
  assign mapped = hit_tx | hit_rx | hit_baud | hit_lo | hit_hi | hit_stat;
  // Any write to either byte restarts the timer, even with pstrb low
  assign div_write = do_write & (hit_lo | hit_hi);

  // ==========================================================
  // Mode decode
  logic sync_mode;
  logic clk_master;
  logic high_speed_select;
  logic wide_divider_select;
  logic port_enable;
  logic gen_run;
  logic [15:0] divisor;
  logic [5:0] post_last;

  assign sync_mode = s_q.tx_status_control[ubg_pkg::TX_SYNC_MODE_BIT];
  assign clk_master = s_q.tx_status_control[ubg_pkg::TX_CLK_MASTER_BIT];
  assign high_speed_select = s_q.tx_status_control[ubg_pkg::TX_HIGH_SPEED_BIT];
  assign wide_divider_select = s_q.baud_control[ubg_pkg::BAUD_WIDE_DIV_BIT];
  assign port_enable = s_q.rx_status_control[ubg_pkg::RX_PORT_ENABLE_BIT];

  // Sync slave takes its clock from the line, so the generator rests
  assign gen_run = port_enable & (~sync_mode | clk_master);

  always_comb
  begin
    if (wide_divider_select)
    begin
      divisor = {s_q.divisor_high_byte, s_q.divisor_low_byte};
    end
    else
    begin
      divisor = {ubg_pkg::BYTE_ZERO, s_q.divisor_low_byte};
    end
  end

  always_comb
  begin
    case ({sync_mode, wide_divider_select, high_speed_select})
      3'b000: post_last = ubg_pkg::POST_LAST_X64;
      3'b010: post_last = ubg_pkg::POST_LAST_X16;
      3'b001: post_last = ubg_pkg::POST_LAST_X16;
      3'b011: post_last = ubg_pkg::POST_LAST_X4;
      default: post_last = ubg_pkg::POST_LAST_X4;
    endcase
  end

  // ==========================================================
  // Generator and pin sampling
  logic timer_tick;
  logic baud_tick;
  logic rx_level;

  ubg_rate_divider u_div
  (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .run_i(gen_run),
    .clear_i(div_write),
    .divisor_i(divisor),
    .post_last_i(post_last),
    .timer_tick_o(timer_tick),
    .baud_tick_o(baud_tick)
  );

  // One sample per timer period; three timer periods keep the vote inside one bit
  ubg_majority_sampler u_smp
  (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .receive_pin_i(receive_pin_i),
    .sample_en_i(timer_tick),
    .rx_level_o(rx_level)
  );

  // ==========================================================
  // Read mux
  logic [31:0] rdata;
  logic [7:0] status;

  always_comb
  begin
    status = ubg_pkg::BYTE_ZERO;
    status[ubg_pkg::STAT_RX_LEVEL_BIT] = rx_level;
    status[ubg_pkg::STAT_RUNNING_BIT] = gen_run;
    rdata = ubg_pkg::RDATA_RESET;
    if (hit_tx)
    begin
      rdata[7:0] = s_q.tx_status_control;
    end
    else if (hit_rx)
    begin
      rdata[7:0] = s_q.rx_status_control;
    end
    else if (hit_baud)
    begin
      rdata[7:0] = s_q.baud_control;
    end
    else if (hit_lo)
    begin
      rdata[7:0] = s_q.divisor_low_byte;
    end
    else if (hit_hi)
    begin
      rdata[7:0] = s_q.divisor_high_byte;
    end
    else if (hit_stat)
    begin
      rdata[7:0] = status;
    end
  end

  // ==========================================================
  // Register and bus state
  always_comb
  begin
    s_d = s_q;
    // One wait state: pready rises in the second access cycle
    s_d.pready = psel_i & penable_i & ~s_q.pready;
    s_d.pslverr = psel_i & penable_i & ~s_q.pready & ~mapped;
    if (psel_i & penable_i & ~s_q.pready & ~pwrite_i)
    begin
      s_d.prdata = rdata;
    end
    if (do_write & low_lane & mapped)
    begin
      if (hit_tx)
      begin
        s_d.tx_status_control = pwdata_i[7:0] & ubg_pkg::TX_WR_MASK;
      end
      if (hit_rx)
      begin
        s_d.rx_status_control = pwdata_i[7:0] & ubg_pkg::RX_WR_MASK;
      end
      if (hit_baud)
      begin
        s_d.baud_control = pwdata_i[7:0] & ubg_pkg::BAUD_WR_MASK;
      end
      if (hit_lo)
      begin
        s_d.divisor_low_byte = pwdata_i[7:0];
      end
      if (hit_hi)
      begin
        s_d.divisor_high_byte = pwdata_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      s_q.tx_status_control <= ubg_pkg::TX_RESET;
      s_q.rx_status_control <= ubg_pkg::RX_RESET;
      s_q.baud_control <= ubg_pkg::BAUD_RESET;
      s_q.divisor_low_byte <= ubg_pkg::DIV_RESET;
      s_q.divisor_high_byte <= ubg_pkg::DIV_RESET;
      s_q.prdata <= ubg_pkg::RDATA_RESET;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign baud_tick_o = baud_tick;
  assign rx_level_o = rx_level;

endmodule : ubg_top

//--- verif/ubg_remote_station.sv
module ubg_remote_station
(
  // Clock and wanted line
  input wire logic clk_sys_i,
  input wire logic line_i,
  input wire logic glitch_i,
  // Receive pin
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A glitch flips the line for as long as it is held
  always_ff @(posedge clk_sys_i) pin_o <= line_i ^ glitch_i;
endmodule : ubg_remote_station

//--- verif/ubg_top_chk.sv
module ubg_top_chk
(
  // Clock, reset and bus
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Line side
  input wire logic receive_pin_i,
  input wire logic baud_tick_o,
  input wire logic rx_level_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================
  // Cycles since the pin was last seen low
  logic [3:0] age_q;
  logic [3:0] age_d;
  logic div_wr;
  assign div_wr = pready_o && pwrite_i && (paddr_i == 8'h0C || paddr_i == 8'h10);
  always_comb age_d = !receive_pin_i ? 4'h0 : (age_q == 4'hF ? age_q : age_q + 4'h1);
  always_ff @(posedge clk_sys_i) age_q <= age_d;
  // ==========================================
  // Properties
  property p_tick_gap; baud_tick_o |=> !baud_tick_o [*3]; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ticks closer than four cycles");
  // Write edge clears the timer, so even n=0, F=4 gives four quiet cycles
  property p_div_clear; div_wr |=> !baud_tick_o [*4]; endproperty
  a_div_clear: assert property (p_div_clear) else $error("tick soon after divisor write");
  property p_rx_reset; $rose(rst_n_i) |-> rx_level_o && !baud_tick_o; endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("bad line state after reset");
  property p_rx_fall; $fell(rx_level_o) |-> age_q < 4'h8; endproperty
  a_rx_fall: assert property (p_rx_fall) else $error("level fell without low pin");
  property p_rdy_pulse; pready_o |=> !pready_o; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  property p_rdy_wait; psel_i && !penable_i |=> !pready_o ##1 pready_o; endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready not in second access");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rd_hi; pready_o |-> prdata_o[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
endmodule : ubg_top_chk

bind ubg_top ubg_top_chk ubg_top_chk_i (.clk_sys_i, .rst_n_i, .pwrite_i, .paddr_i, .psel_i, .penable_i,
  .prdata_o, .pready_o, .pslverr_o, .receive_pin_i, .baud_tick_o, .rx_level_o);

//--- verif/ubg_top_tb.sv
module ubg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'hF;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, receive_pin_i, baud_tick_o, rx_level_o;
  logic line_q = 1'b1;
  logic glitch_q = 1'b0;
  logic [15:0] lfsr = 16'h6FA2;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int last_tick = 0;
  int n_tick = 0;
  logic [32:0] rq[$];
  int pq[$];
  int fa[6] = '{64, 16, 16, 4, 4, 4};
  logic [7:0] ta[6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h94, 8'h90};
  logic [5:0] wa = 6'h2C;
  logic [7:0] ma[5] = '{8'hFD, 8'hF9, 8'h1B, 8'hFF, 8'hFF};

  always #2 clk_sys_i = ~clk_sys_i;

  ubg_top ubg_top_i (.clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .receive_pin_i, .baud_tick_o, .rx_level_o);
  ubg_remote_station ubg_remote_station_i (.clk_sys_i, .line_i(line_q), .glitch_i(glitch_q),
    .pin_o(receive_pin_i));

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic test_done;
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  // ==========================================
  // Bus master; reads note {error, data}
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [32:0] exp);
    int k;
    k = 0;
    if (!wr)
      rq.push_back(exp);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      k++;
    end
    while (pready_o !== 1'b1 && k < 50);
    if (k == 50)
      n_mismatch++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb

  task automatic wait_tick(output int k);
    k = 0;
    do
    begin
      @(posedge clk_sys_i);
      k++;
    end
    while (baud_tick_o !== 1'b1 && k < 20000);
    if (k == 20000)
      n_mismatch++;
  endtask : wait_tick

  // ==========================================
  // Monitor
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (pready_o === 1'b1 && !pwrite_i && rq.size() > 0)
      check({pslverr_o, prdata_o}, rq.pop_front());
    if (baud_tick_o === 1'b1)
    begin
      n_tick++;
      if (pq.size() > 0)
        check(33'(cyc - last_tick), 33'(pq.pop_front()));
      last_tick = cyc;
    end
  end

  initial
  begin
    #400000;
    n_mismatch++;
    test_done();
  end

  initial
  begin
    logic [7:0] v;
    int k;
    int t0;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int i = 0; i < 5; i++)
      apb(1'b0, 8'(i * 4), 8'h00, 33'h0);
    apb(1'b0, 8'h14, 8'h00, 33'h1);
    apb(1'b0, 8'h18, 8'h00, 33'h1_0000_0000);
    apb(1'b0, 8'h01, 8'h00, 33'h1_0000_0000);
    for (int i = 0; i < 5; i++)
    begin
      lfsr = nxt(lfsr);
      v = lfsr[7:0] & ma[i];
      apb(1'b1, 8'(i * 4), lfsr[7:0], 33'h0);
      apb(1'b0, 8'(i * 4), 8'h00, {25'h0, v});
    end
    // A write with no byte strobe keeps the old byte
    pstrb_i <= 4'h0;
    apb(1'b1, 8'h10, ~v, 33'h0);
    pstrb_i <= 4'hF;
    apb(1'b0, 8'h10, 8'h00, {25'h0, v});
    // Clock slave generates nothing
    apb(1'b1, 8'h04, 8'h80, 33'h0);
    apb(1'b1, 8'h08, 8'h00, 33'h0);
    apb(1'b1, 8'h10, 8'h00, 33'h0);
    apb(1'b1, 8'h00, 8'h10, 33'h0);
    apb(1'b1, 8'h0C, 8'h00, 33'h0);
    t0 = n_tick;
    repeat (200) @(posedge clk_sys_i);
    check(33'(n_tick - t0), 33'h0);
    // Every mode, high byte set to 1
    for (int m = 0; m < 6; m++)
    begin
      lfsr = nxt(lfsr);
      apb(1'b1, 8'h00, ta[m], 33'h0);
      apb(1'b1, 8'h08, wa[m] ? 8'h08 : 8'h00, 33'h0);
      apb(1'b1, 8'h10, 8'h01, 33'h0);
      apb(1'b1, 8'h0C, {6'h0, lfsr[1:0]}, 33'h0);
      wait_tick(k);
      @(negedge clk_sys_i);
      pq.push_back(fa[m] * ((wa[m] ? 256 : 0) + lfsr[1:0] + 1));
      wait_tick(k);
    end
    // Long count cut short by a divisor write
    apb(1'b1, 8'h00, 8'h00, 33'h0);
    apb(1'b1, 8'h08, 8'h00, 33'h0);
    apb(1'b1, 8'h0C, 8'hFF, 33'h0);
    repeat (300) @(posedge clk_sys_i);
    apb(1'b1, 8'h0C, 8'h03, 33'h0);
    wait_tick(k);
    // Timer restarts at the write edge: one full period, F=64, n=3
    check(33'(k), 33'(64 * 4));
    // Short glitch ignored, steady low taken
    glitch_q <= 1'b1;
    @(posedge clk_sys_i);
    glitch_q <= 1'b0;
    repeat (30) @(posedge clk_sys_i);
    apb(1'b0, 8'h14, 8'h00, 33'h3);
    check(33'(rx_level_o), 33'h1);
    line_q <= 1'b0;
    repeat (40) @(posedge clk_sys_i);
    apb(1'b0, 8'h14, 8'h00, 33'h2);
    check(33'(rx_level_o), 33'h0);
    test_done();
  end
endmodule : ubg_top_tb
